// *** rtl/nvh_cfg.svh ***
// Timing constants for the nonvolatile static memory host port
`ifndef NVH_CFG_SVH
`define NVH_CFG_SVH
`define NVH_ADDR_W          15
`define NVH_DATA_W          8
`define NVH_CLK_NS          40
`define NVH_T_ACC_NS        45
`define NVH_T_PULL_NS       40
`define NVH_SYNC_CYC        2
`define NVH_ACC_CYC         ((`NVH_T_ACC_NS + `NVH_CLK_NS - 1) / `NVH_CLK_NS)
`define NVH_PULL_CYC        ((`NVH_T_PULL_NS + `NVH_CLK_NS - 1) / `NVH_CLK_NS)
`define NVH_RD_CYC          (`NVH_ACC_CYC + `NVH_SYNC_CYC)
`define NVH_WR_CYC          (`NVH_ACC_CYC)
`define NVH_PULL_LEN        (`NVH_PULL_CYC + `NVH_SYNC_CYC)
`endif

// *** rtl/nvh_pkg.sv ***
// Types for the nonvolatile static memory host port
package nvh_pkg;
    typedef enum logic [2:0] {
        NVH_IDLE   = 3'b000,
        NVH_SETUP  = 3'b001,
        NVH_STROBE = 3'b011,
        NVH_RECOV  = 3'b010,
        NVH_PULL   = 3'b110
    } nvh_state_t;
endpackage

// *** rtl/nvh_sync.sv ***
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module nvh_sync #(
    parameter int W = 1
) (
    input  wire logic         clk_sys,
    input  wire logic         arst_n,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta;

    // First stage feeds only the second stage
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            meta <= '0;
            q    <= '0;
        end else begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule

// *** rtl/nvh_host.sv ***
// Host controller for the byte-wide nonvolatile static memory
// Operation
// RULE_01 - The host puts a 15-bit byte address on the location lines to pick one of 32,768 bytes.
// RULE_02 - Read and write data share one 8-bit two-way bus.
// RULE_03 - The device only answers while chip select is held low by the host.
// RULE_04 - A low write strobe stores the bus byte at the address taken at chip select's falling edge.
// RULE_05 - The device drives read data only while the output gate is low.
// RULE_06 - With the output gate high the device leaves the data bus floating.
// RULE_07 - The device holds the busy pin low through every nonvolatile save.
// RULE_08 - Pulling the busy pin low from outside makes the device save the whole array.
// RULE_09 - A weak pull-up keeps the busy pin high when nobody drives it.
// RULE_10 - On power loss the device saves the whole array by itself.
// RULE_11 - At power-up the device restores the array before normal access.
// RULE_12 - Save and restore can also be started by software.
// RULE_13 - The host starts no access while the busy pin is low and waits for it to rise.
`timescale 1ns/1ps
`include "nvh_cfg.svh"
module nvh_host
    import nvh_pkg::*;
(
    input  wire logic                   clk_sys,
    input  wire logic                   arst_n,
    // User side
    input  wire logic                   acc_req,
    input  wire logic                   acc_write,
    input  wire logic [`NVH_ADDR_W-1:0] acc_addr,
    input  wire logic [`NVH_DATA_W-1:0] acc_wdata,
    input  wire logic                   store_req,
    output logic                        acc_ready,
    output logic                        acc_done,
    output logic      [`NVH_DATA_W-1:0] acc_rdata,
    output logic                        nv_busy,
    // Device pins
    output logic      [`NVH_ADDR_W-1:0] loc_sel_bus,
    output logic                        chip_sel_n,
    output logic                        wr_strobe_n,
    output logic                        out_gate_n,
    input  wire logic [`NVH_DATA_W-1:0] byte_lines_i,
    output logic      [`NVH_DATA_W-1:0] byte_lines_o,
    output logic                        byte_lines_oe,
    input  wire logic                   nv_busy_n_i,
    output logic                        nv_busy_n_o,
    output logic                        nv_busy_n_oe
);
    nvh_state_t             state;
    logic       [2:0]       cnt;
    logic                   is_write;
    logic                   busy_n_s;
    logic [`NVH_DATA_W-1:0] data_s;

    // Select and the active strobe are low from setup until the strobe count runs out
    function automatic logic nvh_strobing(input nvh_state_t st, input logic [2:0] c);
        return (st == NVH_SETUP) || (st == NVH_STROBE && c != 3'h0);
    endfunction

    // Last strobe cycle of an access
    function automatic logic nvh_last(input nvh_state_t st, input logic [2:0] c);
        return (st == NVH_STROBE) && (c == 3'h0);
    endfunction

    // Access taken: idle, no save asked for, busy pin seen high
    function automatic logic nvh_take(input nvh_state_t st, input logic req, input logic sv, input logic bn);
        return (st == NVH_IDLE) && req && !sv && bn;
    endfunction

    // Synchronised busy pin
    nvh_sync #(.W(1)) u_busy_sync (
        .clk_sys (clk_sys),
        .arst_n  (arst_n),
        .d       (nv_busy_n_i),
        .q       (busy_n_s)
    );

    // Synchronised data bus, read only after the byte has stood for two cycles
    nvh_sync #(.W(`NVH_DATA_W)) u_data_sync (
        .clk_sys (clk_sys),
        .arst_n  (arst_n),
        .d       (byte_lines_i),
        .q       (data_s)
    );

    // Busy flag set from reset until the pin is seen high, covering power-up restore
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            nv_busy <= 1'b1;
        end else begin
            nv_busy <= ~busy_n_s;                                     // [RULE_07] [RULE_11]
        end
    end

    // Ready only when a request would be taken at the next edge
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            acc_ready <= 1'b0;
        end else begin
            acc_ready <= (state == NVH_IDLE) && busy_n_s && !acc_req && !store_req; // [RULE_13]
        end
    end

    // Access and store sequencer
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            state    <= NVH_IDLE;
            cnt      <= 3'h0;
            is_write <= 1'b0;
        end else begin
            case (state)
                NVH_IDLE: begin
                    if (store_req) begin
                        state <= NVH_PULL;                            // [RULE_08]
                        cnt   <= 3'(`NVH_PULL_LEN - 1);
                    end else if (nvh_take(state, acc_req, store_req, busy_n_s)) begin
                        state    <= NVH_SETUP;                        // [RULE_13]
                        is_write <= acc_write;
                    end
                end
                NVH_SETUP: begin
                    state <= NVH_STROBE;
                    cnt   <= is_write ? 3'(`NVH_WR_CYC - 1) : 3'(`NVH_RD_CYC - 1);
                end
                NVH_STROBE: begin
                    if (cnt == 3'h0) begin
                        state <= NVH_RECOV;
                    end else begin
                        cnt <= cnt - 3'h1;
                    end
                end
                NVH_RECOV: begin
                    state <= NVH_IDLE;
                end
                // Stays until the synchronised pin can show the save, so no access slips in
                NVH_PULL: begin
                    if (cnt == 3'h0) begin
                        state <= NVH_IDLE;                            // [RULE_13]
                    end else begin
                        cnt <= cnt - 3'h1;
                    end
                end
                default: begin
                    state <= NVH_IDLE;
                end
            endcase
        end
    end

    // Address loaded at the take edge, a cycle before select falls, and held to the end
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            loc_sel_bus <= '0;
        end else begin
            if (nvh_take(state, acc_req, store_req, busy_n_s)) begin
                loc_sel_bus <= acc_addr;                              // [RULE_01]
            end
        end
    end

    // Chip select low only through the strobe cycles
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            chip_sel_n <= 1'b1;
        end else begin
            chip_sel_n <= !nvh_strobing(state, cnt);                  // [RULE_03] [RULE_04]
        end
    end

    // Write strobe, low only for writes
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            wr_strobe_n <= 1'b1;
        end else begin
            wr_strobe_n <= !(is_write && nvh_strobing(state, cnt));   // [RULE_04]
        end
    end

    // Output gate, low only for reads, so it never meets the write strobe
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            out_gate_n <= 1'b1;
        end else begin
            out_gate_n <= !(!is_write && nvh_strobing(state, cnt));   // [RULE_05]
        end
    end

    // Write byte loaded at the take edge
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            byte_lines_o <= '0;
        end else begin
            if (nvh_take(state, acc_req, store_req, busy_n_s) && acc_write) begin
                byte_lines_o <= acc_wdata;                            // [RULE_02]
            end
        end
    end

    // Host drives the bus only for writes, a cycle past the strobe for hold time
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            byte_lines_oe <= 1'b0;
        end else begin
            byte_lines_oe <= (nvh_take(state, acc_req, store_req, busy_n_s) && acc_write) ||
                             (is_write && (state == NVH_SETUP || state == NVH_STROBE)); // [RULE_02] [RULE_06]
        end
    end

    // Busy pin: pulled low by the host to request a save, else released
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            nv_busy_n_o  <= 1'b0;
            nv_busy_n_oe <= 1'b0;
        end else begin
            nv_busy_n_o  <= 1'b0;
            nv_busy_n_oe <= (state == NVH_IDLE && store_req) ||
                            (state == NVH_PULL && cnt > 3'(`NVH_SYNC_CYC)); // [RULE_08] [RULE_12]
        end
    end

    // Completion pulse in the cycle after the last strobe cycle
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            acc_done <= 1'b0;
        end else begin
            acc_done <= nvh_last(state, cnt);
        end
    end

    // Read byte captured with the completion pulse
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            acc_rdata <= '0;
        end else begin
            if (nvh_last(state, cnt) && !is_write) begin
                acc_rdata <= data_s;                                  // [RULE_02] [RULE_05]
            end
        end
    end
endmodule

// *** rtl/unused_none.sv ***
// This file holds no logic

// *** tb/nvh_monitor.sv ***
// Assertion checker for the host port of the nonvolatile memory
`timescale 1ns/1ps
`include "nvh_cfg.svh"
module nvh_monitor (
    input wire logic                   clk_sys,
    input wire logic                   arst_n,
    input wire logic                   store_req,
    input wire logic                   acc_ready,
    input wire logic                   acc_done,
    input wire logic                   nv_busy,
    input wire logic [`NVH_ADDR_W-1:0] loc_sel_bus,
    input wire logic                   chip_sel_n,
    input wire logic                   wr_strobe_n,
    input wire logic                   out_gate_n,
    input wire logic                   byte_lines_oe,
    input wire logic                   nv_busy_n_i,
    input wire logic                   nv_busy_n_o,
    input wire logic                   nv_busy_n_oe
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    // Steps of an access and of a seen save
    sequence s_sel_fall; $fell(chip_sel_n); endsequence
    sequence s_done_soon; ##[2:6] acc_done; endsequence
    sequence s_pin_low; !nv_busy_n_i [*4]; endsequence
    sequence s_pull_start; $rose(nv_busy_n_oe); endsequence
    sequence s_quiet; (chip_sel_n && !acc_ready) [*4]; endsequence
    AST_GATE_FREE: assert property (!out_gate_n |-> !byte_lines_oe)
        else $error("host drives bus while output gate is low");
    AST_WR_SEL: assert property (!wr_strobe_n |-> !chip_sel_n && byte_lines_oe && out_gate_n)
        else $error("write strobe without select or data");
    AST_ADDR_HOLD: assert property (!chip_sel_n && $past(!chip_sel_n) |-> $stable(loc_sel_bus))
        else $error("address moved during select");
    AST_SEL_DONE: assert property (s_sel_fall |-> s_done_soon)
        else $error("access did not finish in time");
    AST_DONE_IDLE: assert property (acc_done |-> chip_sel_n ##1 !acc_done)
        else $error("done not a single pulse after deselect");
    AST_READY_IDLE: assert property (acc_ready |-> !nv_busy && chip_sel_n)
        else $error("ready while busy or selected");
    AST_BUSY_SEEN: assert property (s_pin_low |-> nv_busy)
        else $error("busy pin low but busy flag low");
    AST_PULL_PULSE: assert property (nv_busy_n_oe |-> !nv_busy_n_o ##1 !nv_busy_n_oe)
        else $error("busy pull not one low cycle");
    AST_PULL_CAUSE: assert property ($rose(nv_busy_n_oe) |-> $past(store_req))
        else $error("busy pull without save request");
    AST_PULL_HOLD: assert property (s_pull_start |-> s_quiet)
        else $error("access offered before the save shows on the pin");
endmodule

bind nvh_host nvh_monitor u_mon (
    .clk_sys       (clk_sys),
    .arst_n        (arst_n),
    .store_req     (store_req),
    .acc_ready     (acc_ready),
    .acc_done      (acc_done),
    .nv_busy       (nv_busy),
    .loc_sel_bus   (loc_sel_bus),
    .chip_sel_n    (chip_sel_n),
    .wr_strobe_n   (wr_strobe_n),
    .out_gate_n    (out_gate_n),
    .byte_lines_oe (byte_lines_oe),
    .nv_busy_n_i   (nv_busy_n_i),
    .nv_busy_n_o   (nv_busy_n_o),
    .nv_busy_n_oe  (nv_busy_n_oe)
);

// *** tb/nvh_mem_model.sv ***
// Behavioural model of the byte-wide nonvolatile static memory
`timescale 1ns/1ps
module nvh_mem_model #(
    parameter int STORE_NS  = 2000,
    parameter int RECALL_NS = 1500
) (
    input  wire logic [14:0] loc_sel_bus,
    input  wire logic        chip_sel_n,
    input  wire logic        wr_strobe_n,
    input  wire logic        out_gate_n,
    input  wire logic [7:0]  dq_in,
    output logic      [7:0]  dq_out,
    input  wire logic        busy_pin,
    output logic             busy_drv
);
    logic [7:0]  sram [0:32767];
    logic [7:0]  nv   [0:32767];
    logic [14:0] lat_addr;
    event        recall_ev;
    // Power-up restore, busy pin held low meanwhile
    initial begin
        busy_drv = 1'b1;
        for (int i = 0; i < 32768; i++) nv[i] = i[7:0] ^ 8'h5a;
        #RECALL_NS;
        for (int i = 0; i < 32768; i++) sram[i] = nv[i];
        busy_drv = 1'b0;
    end
    // Whole-array save when the pin is pulled low from outside
    always @(negedge busy_pin) begin
        if (!busy_drv) begin
            busy_drv = 1'b1;
            for (int i = 0; i < 32768; i++) nv[i] = sram[i];
            #STORE_NS;
            busy_drv = 1'b0;
        end
    end
    // Restore started by a software command, busy pin held low meanwhile
    always @(recall_ev) begin
        busy_drv = 1'b1;
        #RECALL_NS;
        for (int i = 0; i < 32768; i++) sram[i] = nv[i];
        busy_drv = 1'b0;
    end
    // Address follows the lines while deselected and is held from select's falling edge
    always @(chip_sel_n or loc_sel_bus) begin
        if (chip_sel_n) lat_addr = loc_sel_bus;
    end
    // Byte stored while select and strobe are low
    always @(wr_strobe_n or dq_in or chip_sel_n or lat_addr) begin
        if (!chip_sel_n && !wr_strobe_n && !busy_drv) sram[lat_addr] = dq_in;
    end
    // Floating bus shows the inverted byte
    assign dq_out = (!chip_sel_n && !out_gate_n && wr_strobe_n && !busy_drv) ?
                    sram[loc_sel_bus] : ~sram[loc_sel_bus];
endmodule

// *** tb/testbench.sv ***
// Self-checking bench for the nonvolatile memory host port
`timescale 1ns/1ps
module testbench;
    logic        clk_sys, arst_n, acc_req, acc_write, store_req, acc_ready, acc_done, nv_busy;
    logic        chip_sel_n, wr_strobe_n, out_gate_n, byte_lines_oe, nv_busy_n_o, nv_busy_n_oe, busy_drv;
    logic [14:0] acc_addr, loc_sel_bus;
    logic [7:0]  acc_wdata, acc_rdata, byte_lines_o, dev_q, ref_mem [int], saved [int];
    logic [31:0] r;
    int          num_errors, comparisons, seed, n;
    wire         busy_pin = !(nv_busy_n_oe && !nv_busy_n_o) && !busy_drv;
    wire  [7:0]  dq = byte_lines_oe ? byte_lines_o : dev_q;
    always #20 clk_sys = ~clk_sys;
    nvh_host u_dut (.clk_sys(clk_sys), .arst_n(arst_n), .acc_req(acc_req), .acc_write(acc_write),
        .acc_addr(acc_addr), .acc_wdata(acc_wdata), .store_req(store_req), .acc_ready(acc_ready),
        .acc_done(acc_done), .acc_rdata(acc_rdata), .nv_busy(nv_busy), .loc_sel_bus(loc_sel_bus),
        .chip_sel_n(chip_sel_n), .wr_strobe_n(wr_strobe_n), .out_gate_n(out_gate_n), .byte_lines_i(dq),
        .byte_lines_o(byte_lines_o), .byte_lines_oe(byte_lines_oe), .nv_busy_n_i(busy_pin),
        .nv_busy_n_o(nv_busy_n_o), .nv_busy_n_oe(nv_busy_n_oe));
    nvh_mem_model u_mem (.loc_sel_bus(loc_sel_bus), .chip_sel_n(chip_sel_n), .wr_strobe_n(wr_strobe_n),
        .out_gate_n(out_gate_n), .dq_in(dq), .dq_out(dev_q), .busy_pin(busy_pin), .busy_drv(busy_drv));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic results();
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    function automatic logic [7:0] exp_byte(input logic [14:0] a);
        return ref_mem.exists(a) ? ref_mem[a] : a[7:0] ^ 8'h5a;
    endfunction
    // Bounded wait for ready, done or busy to reach a level
    task automatic wait_on(input int which, input logic lvl, input int lim);
        n = 0;
        while ((which == 0 ? acc_ready : which == 1 ? acc_done : nv_busy) !== lvl) begin
            @(negedge clk_sys);
            n++;
            if (n > lim) begin
                num_errors++;
                results();
            end
        end
    endtask
    task automatic access(input logic w, input logic [14:0] a, input logic [7:0] d);
        wait_on(0, 1'b1, 300);
        {acc_req, acc_write, acc_addr, acc_wdata} = {1'b1, w, a, d};
        @(negedge clk_sys);
        acc_req = 1'b0;
        wait_on(1, 1'b1, 10);
        if (w) ref_mem[a] = d;
        else check(acc_rdata, exp_byte(a), "read byte");
    endtask
    initial begin
        {clk_sys, arst_n, acc_req, acc_write, store_req, acc_addr, acc_wdata} = '0;
        {num_errors, comparisons, seed} = {32'd0, 32'd0, 32'd47814};
        repeat (12) @(negedge clk_sys);
        check(chip_sel_n & out_gate_n & nv_busy, 1'b1, "pins in reset");
        arst_n = 1'b1;
        repeat (10) @(negedge clk_sys);
        check({acc_ready, nv_busy}, 2'b01, "ready during restore");
        access(1'b1, 15'h0000, 8'ha5);
        access(1'b1, 15'h7fff, 8'h3c);
        for (int i = 0; i < 24; i++) begin
            r = $random(seed);
            access(1'b1, r[14:0], r[22:15]);
            access(1'b0, r[14:0], 8'h00);
            access(1'b0, ~r[14:0], 8'h00);
        end
        wait_on(0, 1'b1, 300);
        {store_req, acc_req} = 2'b11;
        @(negedge clk_sys);
        {store_req, acc_req} = 2'b00;
        wait_on(2, 1'b1, 10);
        wait_on(2, 1'b0, 200);
        foreach (ref_mem[k]) check(u_mem.nv[k], ref_mem[k], "saved byte");
        foreach (ref_mem[k]) access(1'b0, k[14:0], 8'h00);
        saved = ref_mem;
        access(1'b1, 15'h0000, 8'h0f);
        access(1'b1, 15'h7fff, 8'hf0);
        access(1'b0, 15'h0000, 8'h00);
        -> u_mem.recall_ev;
        wait_on(2, 1'b1, 10);
        check(acc_ready, 1'b0, "ready during recall");
        wait_on(2, 1'b0, 200);
        ref_mem = saved;
        foreach (ref_mem[k]) access(1'b0, k[14:0], 8'h00);
        results();
    end
endmodule
